// *** core/psa_regs.svh ***
`ifndef PSA_REGS_SVH
`define PSA_REGS_SVH
// Register byte offsets on the bus.
`define PSA_OFS_TPAGE 4'h0
`define PSA_OFS_VPAGE 4'h4
`define PSA_OFS_CPUCTL 4'h8
`define PSA_OFS_STATUS 4'hC
// Reset values.
`define PSA_RST_TPAGE 8'h00
`define PSA_RST_VPAGE 8'h00
`define PSA_RST_CPUCTL 16'h0000
// Field positions.
`define PSA_CPUCTL_VIS_BIT 2
`define PSA_TPAGE_CFG_BIT 7
`define PSA_EA_REMAP_BIT 15
// Extra cycles of a remapped read.
`define PSA_PEN_MOVE 2'h1
`define PSA_PEN_OTHER 2'h2
`define PSA_PEN_LOOP_EDGE 2'h2
`define PSA_PEN_LOOP_BODY 2'h0
// Self-programming block sizes, in instructions.
`define PSA_ROW_INSTR 64
`define PSA_ERASE_INSTR 512
`endif

// *** core/psa_pkg.sv ***
package psa_pkg;
   // Kinds of access the core may issue.
   typedef enum logic [2:0] {
      OP_DATA_READ,
      OP_TABLE_READ_LOW,
      OP_TABLE_READ_HIGH,
      OP_TABLE_WRITE_LOW,
      OP_TABLE_WRITE_HIGH
   } psa_op_t;
   // Instruction class, which sets the remap cost.
   typedef enum logic [1:0] {
      IC_MOVE,
      IC_DOUBLE_MOVE,
      IC_OTHER
   } psa_iclass_t;
   // One access request from the core.
   typedef struct packed {
      psa_op_t op;
      logic [15:0] effective_address;
      logic byte_mode;
      logic [15:0] wdata;
      psa_iclass_t iclass;
      logic in_loop;
      logic loop_edge;
   } psa_req_t;
   // Answer to the core.
   typedef struct packed {
      logic [15:0] rdata;
      logic to_data_mem;
      logic remapped;
      logic refused;
   } psa_rsp_t;
   // Write into the holding latches.
   typedef struct packed {
      logic [23:0] addr;
      logic high;
      logic [1:0] lanes;
      logic [15:0] data;
   } psa_latch_t;
   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_PENALTY
   } psa_state_t;
endpackage : psa_pkg

// *** core/psa_top.sv ***
// Behaviour
// [RULE_01] Table address is page over effective address.
// [RULE_02] Page bit 7 selects configuration space.
// [RULE_03] Remap address: page plus low 15 bits.
// [RULE_04] Remap only if bit 15 and enabled.
// [RULE_05] Window is upper 32K, 256 pages.
// [RULE_06] Addresses step by two per word.
// [RULE_07] Word read low returns bits 15:0.
// [RULE_08] Byte read low picks byte by select.
// [RULE_09] Word read high zero fills upper byte.
// [RULE_10] Byte read high phantom byte reads zero.
// [RULE_11] Only high ops touch upper eight bits.
// [RULE_12] Configuration space reads only, implemented areas.
// [RULE_13] Remapped read returns low 16 bits.
// [RULE_14] Remap suspended during table operations.
// [RULE_15] Remap costs one or two cycles.
// [RULE_16] Loop remap costs two at edges only.
// [RULE_17] Rows of 64, erase blocks of 512.
// [RULE_18] Software pads constants' upper byte.
// [RULE_19] Table writes only reach holding latches.
// [RULE_20] Plain data access goes to data memory.
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "psa_regs.svh"
module psa_top #(
   // Implemented configuration area, inclusive word addresses.
   parameter logic [23:0] CFG_IMPL_LO = 24'hF8_0000,
   parameter logic [23:0] CFG_IMPL_HI = 24'hFF_FFFE
) (
   // Clock, reset and enable.
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // AHB-Lite slave.
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   // Core request and answer.
   input wire logic i_req_valid,
   input wire psa_pkg::psa_req_t i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output psa_pkg::psa_rsp_t o_rsp,
   // Program memory read port.
   output logic o_pm_rd,
   output logic [23:0] o_pm_addr,
   input wire logic [23:0] i_pm_rdata,
   // Holding latch write port.
   output logic o_latch_wr,
   output psa_pkg::psa_latch_t o_latch
);

   // Bus address phase captured for the data phase.
   logic wr_pend_reg, wr_pend_next;
   logic [3:0] wr_ofs_reg, wr_ofs_next;
   logic [31:0] hrdata_reg, hrdata_next;
   // Software visible registers.
   logic [7:0] tpage_reg, tpage_next;
   logic [7:0] vpage_reg, vpage_next;
   logic [15:0] cpuctl_reg, cpuctl_next;
   logic [7:0] refused_cnt_reg, refused_cnt_next;
   // Sequencer state.
   psa_pkg::psa_state_t state_reg, state_next;
   psa_pkg::psa_req_t req_reg, req_next;
   logic [1:0] pen_reg, pen_next;
   logic [15:0] data_reg, data_next;
   // Registered outputs toward the core and memory.
   logic ready_reg, ready_next;
   logic rsp_valid_reg, rsp_valid_next;
   psa_pkg::psa_rsp_t rsp_reg, rsp_next;
   logic pm_rd_reg, pm_rd_next;
   logic [23:0] pm_addr_reg, pm_addr_next;
   logic latch_wr_reg, latch_wr_next;
   psa_pkg::psa_latch_t latch_reg, latch_next;
   // Decoded view of the incoming request.
   logic take;
   logic is_table;
   logic is_write;
   logic vis_on;
   logic remap;
   logic cfg_space;
   logic cfg_ok;
   logic [23:0] tbl_addr;
   logic [23:0] vis_addr;

   // Extra cycles owed by a remapped read.
   function automatic logic [1:0] remap_penalty(input psa_pkg::psa_req_t r);
      logic [1:0] p;
      p = `PSA_PEN_OTHER;
      if (r.in_loop)
      begin
         // [RULE_16] Loop edge cost
         p = r.loop_edge ? `PSA_PEN_LOOP_EDGE : `PSA_PEN_LOOP_BODY;
      end
      else if (r.iclass != psa_pkg::IC_OTHER)
      begin
         // [RULE_15] Move cost one
         p = `PSA_PEN_MOVE;
      end
      return p;
   endfunction : remap_penalty

   // Steer a program word onto the 16-bit data lanes.
   function automatic logic [15:0] steer(input psa_pkg::psa_req_t r,
                                         input logic [23:0] w);
      logic [15:0] d;
      d = 16'h0000;
      case (r.op)
         psa_pkg::OP_TABLE_READ_LOW:
         begin
            if (!r.byte_mode)
            begin
               // [RULE_07] Word low read
               d = w[15:0];
            end
            else
            begin
               // [RULE_08] Byte select lane
               d = {8'h00, r.effective_address[0] ? w[15:8] : w[7:0]};
            end
         end
         psa_pkg::OP_TABLE_READ_HIGH:
         begin
            // [RULE_09] Phantom byte zero
            // [RULE_10] Byte select phantom
            if (!(r.byte_mode && r.effective_address[0]))
            begin
               d = {8'h00, w[23:16]};
            end
         end
         default:
         begin
            // [RULE_13] Remap low word
            d = w[15:0];
         end
      endcase
      return d;
   endfunction : steer

   // Decode of the request as offered this cycle.
   always_comb
   begin
      take = i_ce && i_req_valid && ready_reg;
      is_table = (i_req.op != psa_pkg::OP_DATA_READ);
      is_write = (i_req.op == psa_pkg::OP_TABLE_WRITE_LOW) ||
                 (i_req.op == psa_pkg::OP_TABLE_WRITE_HIGH);
      vis_on = cpuctl_reg[`PSA_CPUCTL_VIS_BIT];
      // [RULE_04] Remap route condition
      // [RULE_05] Upper half window
      remap = !is_table && vis_on && i_req.effective_address[`PSA_EA_REMAP_BIT];
      // [RULE_01] Page over address
      // [RULE_06] Two per word
      tbl_addr = {tpage_reg, i_req.effective_address};
      // [RULE_03] Bit 15 dropped
      vis_addr = {1'b0, vpage_reg, i_req.effective_address[14:0]};
      // [RULE_02] Configuration select bit
      cfg_space = tpage_reg[`PSA_TPAGE_CFG_BIT];
      cfg_ok = (tbl_addr >= CFG_IMPL_LO) && (tbl_addr <= CFG_IMPL_HI);
   end

   // Sequencer next state and registered outputs toward the core.
   always_comb
   begin
      state_next = state_reg;
      req_next = req_reg;
      pen_next = pen_reg;
      data_next = data_reg;
      rsp_valid_next = 1'b0;
      rsp_next = rsp_reg;
      pm_rd_next = 1'b0;
      pm_addr_next = pm_addr_reg;
      latch_wr_next = 1'b0;
      latch_next = latch_reg;
      refused_cnt_next = refused_cnt_reg;
      case (state_reg)
         psa_pkg::ST_IDLE:
         begin
            if (take)
            begin
               req_next = i_req;
               rsp_next = '0;
               if (!is_table && !remap)
               begin
                  // [RULE_20] Plain data access
                  rsp_valid_next = 1'b1;
                  rsp_next.to_data_mem = 1'b1;
               end
               else if (is_table && cfg_space && (is_write || !cfg_ok))
               begin
                  // [RULE_12] Configuration refuse
                  rsp_valid_next = 1'b1;
                  rsp_next.refused = 1'b1;
                  refused_cnt_next = refused_cnt_reg + 8'h01;
               end
               else if (is_write)
               begin
                  // [RULE_19] Holding latch only
                  // [RULE_11] High lane write
                  // [RULE_17] Full address for row grouping
                  latch_wr_next = 1'b1;
                  latch_next.addr = tbl_addr;
                  latch_next.high = (i_req.op == psa_pkg::OP_TABLE_WRITE_HIGH);
                  latch_next.data = i_req.wdata;
                  if (!i_req.byte_mode)
                  begin
                     latch_next.lanes = 2'h3;
                  end
                  else
                  begin
                     latch_next.lanes = i_req.effective_address[0] ? 2'h2 : 2'h1;
                  end
                  rsp_valid_next = 1'b1;
               end
               else
               begin
                  // Reads fetch from program memory first.
                  pm_rd_next = 1'b1;
                  pm_addr_next = remap ? vis_addr : tbl_addr;
                  pen_next = remap ? remap_penalty(i_req) : 2'h0;
                  rsp_next.remapped = remap;
                  state_next = psa_pkg::ST_FETCH;
               end
            end
         end
         psa_pkg::ST_FETCH:
         begin
            // Word is taken in the same cycle as the read strobe.
            data_next = steer(req_reg, i_pm_rdata);
            if (pen_reg == 2'h0)
            begin
               rsp_valid_next = 1'b1;
               rsp_next.rdata = steer(req_reg, i_pm_rdata);
               state_next = psa_pkg::ST_IDLE;
            end
            else
            begin
               state_next = psa_pkg::ST_PENALTY;
            end
         end
         psa_pkg::ST_PENALTY:
         begin
            // The second program fetch of a remap is modelled as stall cycles.
            pen_next = pen_reg - 2'h1;
            if (pen_reg == 2'h1)
            begin
               rsp_valid_next = 1'b1;
               rsp_next.rdata = data_reg;
               state_next = psa_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_next = psa_pkg::ST_IDLE;
         end
      endcase
      // [RULE_14] Busy blocks remap
      ready_next = (state_next == psa_pkg::ST_IDLE);
   end

   // Bus slave next state: zero-wait, every response OKAY.
   always_comb
   begin
      wr_pend_next = 1'b0;
      wr_ofs_next = wr_ofs_reg;
      hrdata_next = hrdata_reg;
      tpage_next = tpage_reg;
      vpage_next = vpage_reg;
      cpuctl_next = cpuctl_reg;
      // Data phase of a write lands in the addressed register.
      if (wr_pend_reg)
      begin
         case (wr_ofs_reg)
            `PSA_OFS_TPAGE:
            begin
               tpage_next = i_hwdata[7:0];
            end
            `PSA_OFS_VPAGE:
            begin
               vpage_next = i_hwdata[7:0];
            end
            `PSA_OFS_CPUCTL:
            begin
               cpuctl_next = i_hwdata[15:0];
            end
            default:
            begin
               // Status and unmapped words ignore writes.
               cpuctl_next = cpuctl_reg;
            end
         endcase
      end
      // Address phase: reads are prepared now so data stands next cycle.
      if (i_hsel && i_hready && i_htrans[1])
      begin
         wr_pend_next = i_hwrite;
         wr_ofs_next = i_haddr[3:0];
         hrdata_next = 32'h0000_0000;
         if (!i_hwrite)
         begin
            case (i_haddr[3:0])
               `PSA_OFS_TPAGE:
               begin
                  hrdata_next = {24'h00_0000, tpage_reg};
               end
               `PSA_OFS_VPAGE:
               begin
                  hrdata_next = {24'h00_0000, vpage_reg};
               end
               `PSA_OFS_CPUCTL:
               begin
                  hrdata_next = {16'h0000, cpuctl_reg};
               end
               `PSA_OFS_STATUS:
               begin
                  hrdata_next = {14'h0000, state_reg, refused_cnt_reg, pm_addr_reg[23:16]};
               end
               default:
               begin
                  hrdata_next = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Register every group; the enable freezes everything while low.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_pend_reg <= 1'b0;
         wr_ofs_reg <= 4'h0;
         hrdata_reg <= 32'h0000_0000;
         tpage_reg <= `PSA_RST_TPAGE;
         vpage_reg <= `PSA_RST_VPAGE;
         cpuctl_reg <= `PSA_RST_CPUCTL;
         refused_cnt_reg <= 8'h00;
         state_reg <= psa_pkg::ST_IDLE;
         req_reg <= '0;
         pen_reg <= 2'h0;
         data_reg <= 16'h0000;
         ready_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_reg <= '0;
         pm_rd_reg <= 1'b0;
         pm_addr_reg <= 24'h00_0000;
         latch_wr_reg <= 1'b0;
         latch_reg <= '0;
      end
      else if (i_ce)
      begin
         wr_pend_reg <= wr_pend_next;
         wr_ofs_reg <= wr_ofs_next;
         hrdata_reg <= hrdata_next;
         tpage_reg <= tpage_next;
         vpage_reg <= vpage_next;
         cpuctl_reg <= cpuctl_next;
         refused_cnt_reg <= refused_cnt_next;
         state_reg <= state_next;
         req_reg <= req_next;
         pen_reg <= pen_next;
         data_reg <= data_next;
         ready_reg <= ready_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_reg <= rsp_next;
         pm_rd_reg <= pm_rd_next;
         pm_addr_reg <= pm_addr_next;
         latch_wr_reg <= latch_wr_next;
         latch_reg <= latch_next;
      end
   end

   // Outputs come straight from flip-flops, except hreadyout and hresp, which are tied to constants.
   assign o_hreadyout = 1'b1;
   assign o_hrdata = hrdata_reg;
   assign o_hresp = 1'b0;
   assign o_req_ready = ready_reg;
   assign o_rsp_valid = rsp_valid_reg;
   assign o_rsp = rsp_reg;
   assign o_pm_rd = pm_rd_reg;
   assign o_pm_addr = pm_addr_reg;
   assign o_latch_wr = latch_wr_reg;
   assign o_latch = latch_reg;

endmodule : psa_top
`default_nettype wire

// *** tb/psa_top_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module psa_top_monitor (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Bus answer.
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   // Core side.
   input wire logic i_req_valid,
   input wire psa_pkg::psa_req_t i_req,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire psa_pkg::psa_rsp_t o_rsp,
   // Memory side.
   input wire logic o_pm_rd,
   input wire logic [23:0] o_pm_addr,
   input wire logic o_latch_wr,
   input wire psa_pkg::psa_latch_t o_latch
);
   // A request is accepted on this edge.
   logic take;
   // The accepted request is a table read.
   logic trd;
   // Last accepted op, so answers can be judged later.
   psa_pkg::psa_op_t last_reg;
   psa_pkg::psa_op_t last_next;
   assign take = o_req_ready && i_req_valid && i_ce;
   assign trd = i_req.op inside {psa_pkg::OP_TABLE_READ_LOW, psa_pkg::OP_TABLE_READ_HIGH};
   // Next value of the remembered op.
   always_comb last_next = i_rst ? psa_pkg::OP_DATA_READ : (take ? i_req.op : last_reg);
   // Registers the remembered op.
   always_ff @(posedge i_clk) last_reg <= last_next;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_tbl_addr: assert property (take && trd |=> (o_pm_rd |->
      o_pm_addr[15:1] == $past(i_req.effective_address[15:1]))) else $error("table address");
   chk_remap_addr: assert property (take && i_req.op == psa_pkg::OP_DATA_READ
      && i_req.effective_address[15] |=> (o_pm_rd |-> !o_pm_addr[23]
      && o_pm_addr[14:1] == $past(i_req.effective_address[14:1]))) else $error("remap address");
   chk_plain_data: assert property (take && i_req.op == psa_pkg::OP_DATA_READ
      && !i_req.effective_address[15] |=> o_rsp_valid && o_rsp.to_data_mem && !o_pm_rd)
      else $error("plain data access");
   chk_high_zero: assert property (o_rsp_valid
      && last_reg == psa_pkg::OP_TABLE_READ_HIGH
      |-> o_rsp.rdata[15:8] == 8'h00) else $error("phantom byte not zero");
   chk_tbl_noremap: assert property (o_rsp_valid && last_reg != psa_pkg::OP_DATA_READ
      |-> !o_rsp.remapped) else $error("remap during table op");
   chk_latch_cause: assert property (o_latch_wr
      |-> !o_latch.addr[23] && last_reg inside
      {psa_pkg::OP_TABLE_WRITE_LOW, psa_pkg::OP_TABLE_WRITE_HIGH}) else $error("bad latch");
   chk_latch_high: assert property (o_latch_wr
      |-> o_latch.high == (last_reg == psa_pkg::OP_TABLE_WRITE_HIGH)) else $error("latch half");
   // A latch strobe follows only an accepted request, or stands frozen while the enable is low.
   chk_latch_pulse: assert property (o_latch_wr
      |-> ($past(take) || !$past(i_ce)) && !o_pm_rd) else $error("latch pulse");
   chk_resp_bound: assert property (take
      |-> ##[1:6] o_rsp_valid) else $error("no answer");
   chk_bus_okay: assert property (o_hreadyout && !o_hresp) else $error("bus answer");
endmodule : psa_top_monitor
bind psa_top psa_top_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
   .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_req_valid(i_req_valid), .i_req(i_req),
   .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp(o_rsp), .o_pm_rd(o_pm_rd),
   .o_pm_addr(o_pm_addr), .o_latch_wr(o_latch_wr), .o_latch(o_latch));
`default_nettype wire

// *** tb/psa_pmem.sv ***
`timescale 1ns/10ps
`default_nettype none
module psa_pmem (
   // Clock, unused because the block reads the word while its strobe stands.
   input wire logic i_clk,
   // Read port from the block.
   input wire logic i_pm_rd,
   input wire logic [23:0] i_pm_addr,
   output logic [23:0] o_pm_rdata
);
   // Contents depend on page and word, never on the byte select bit.
   // Upper byte all-ones/zeros
   function automatic logic [23:0] pm_word(input logic [23:0] a);
      return {{8{a[1] ^ a[17]}}, a[16:1] ^ {a[23:16], 8'h3C}};
   endfunction : pm_word
   // The word shows only while the strobe stands; otherwise its inverse, so a capture in the
   // wrong cycle is caught.
   always_comb o_pm_rdata = i_pm_rd ? pm_word(i_pm_addr) : ~pm_word(i_pm_addr);
endmodule : psa_pmem
`default_nettype wire

// *** tb/psa_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module psa_top_bench;
   // Stimulus.
   logic i_clk = 1'b0, i_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rq_v = 1'b0, ce = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   psa_pkg::psa_req_t rq = '0;
   // Design answers.
   logic hready, hresp, rq_rdy, rsp_v, pm_rd, lw, seen;
   logic [31:0] hrdata;
   logic [23:0] pm_a, pm_d, w;
   psa_pkg::psa_rsp_t rsp;
   psa_pkg::psa_latch_t lt, lts;
   int fails = 0, cmp_count = 0, lat, lat0;
   logic [7:0] tp, vp;
   logic [15:0] ea;
   // Remap cases: class, extra cycles over a table read.
   psa_pkg::psa_iclass_t ics[5] = '{psa_pkg::IC_MOVE, psa_pkg::IC_DOUBLE_MOVE,
      psa_pkg::IC_OTHER, psa_pkg::IC_OTHER, psa_pkg::IC_MOVE};
   int pen[5] = '{1, 1, 2, 2, 0};
   always #12.5 i_clk = ~i_clk;
   psa_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
      .i_req_valid(rq_v), .i_req(rq), .o_req_ready(rq_rdy), .o_rsp_valid(rsp_v),
      .o_rsp(rsp), .o_pm_rd(pm_rd), .o_pm_addr(pm_a), .i_pm_rdata(pm_d),
      .o_latch_wr(lw), .o_latch(lt));
   psa_pmem pm (.i_clk(i_clk), .i_pm_rd(pm_rd), .i_pm_addr(pm_a), .o_pm_rdata(pm_d));
   // One single-word bus transfer; read data lands in rd.
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge i_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      // Address phase holds until hready is seen high at a rising edge.
      do @(posedge i_clk); while (!hready);
      htrans <= 2'h0;
      hwdata <= d;
      // Data phase holds likewise; read data is taken at that same edge.
      do @(posedge i_clk); while (!hready);
      rd = hrdata;
   endtask : bus
   // One core request at address ea; counts cycles to the answer.
   task automatic req(input psa_pkg::psa_op_t op, input logic bm,
      input psa_pkg::psa_iclass_t ic, input logic lp, input logic le);
      @(posedge i_clk);
      rq <= '{op: op, effective_address: ea, byte_mode: bm, wdata: ea ^ 16'h5A5A,
         iclass: ic, in_loop: lp, loop_edge: le};
      rq_v <= 1'b1;
      do @(negedge i_clk); while (!rq_rdy);
      @(posedge i_clk);
      rq_v <= 1'b0;
      lat = 0;
      seen = 1'b0;
      do
      begin
         @(negedge i_clk);
         lat++;
         if (lw) {seen, lts} = {1'b1, lt};
      end
      while (!rsp_v && lat < 20);
      `CHK("rsp_valid", 1'b1, rsp_v)
   endtask : req
   // Expected table read data from a program word.
   function automatic logic [15:0] ex(input logic hi, input logic bm, input logic s);
      if (!hi)
         return bm ? {8'h00, s ? w[15:8] : w[7:0]} : w[15:0];
      return (bm && s) ? 16'h0000 : {8'h00, w[23:16]};
   endfunction : ex
   task automatic test_done;
      $display("TB: comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   // Watchdog against a hang.
   initial
   begin
      #200000;
      fails++;
      test_done();
   end
   initial
   begin
      void'($urandom(32'h85DF5A0F));
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int i = 0; i < 16; i += 4)
      begin
         bus(1'b0, i, 32'h0);
         `CHK("reset_value", 32'h0, rd)
      end
      // Visibility on, so table ops show it stays suspended.
      bus(1'b1, 32'h8, 32'h4);
      for (int i = 0; i < 8; i++)
      begin
         tp = 8'($urandom) & 8'h7F;
         ea = 16'($urandom);
         bus(1'b1, 32'h0, {24'h0, tp});
         bus(1'b0, 32'h0, 32'h0);
         `CHK("table_page", {24'h0, tp}, rd)
         req(i[0] ? psa_pkg::OP_TABLE_READ_HIGH : psa_pkg::OP_TABLE_READ_LOW, i[1],
            psa_pkg::IC_OTHER, i[2], 1'b1);
         w = pm.pm_word({tp, ea});
         `CHK("table_rdata", ex(i[0], i[1], ea[0]), rsp.rdata)
         `CHK("table_remap", 1'b0, rsp.remapped)
         lat0 = lat;
      end
      for (int i = 0; i < 5; i++)
      begin
         vp = 8'($urandom);
         ea = 16'($urandom) | 16'h8000;
         bus(1'b1, 32'h4, {24'h0, vp});
         req(psa_pkg::OP_DATA_READ, 1'b0, ics[i], i > 2, i == 3);
         w = pm.pm_word({1'b0, vp, ea[14:0]});
         `CHK("remap_rdata", w[15:0], rsp.rdata)
         `CHK("remap_flag", 1'b1, rsp.remapped)
         `CHK("remap_cost", lat0 + pen[i], lat)
      end
      for (int i = 0; i < 2; i++)
      begin
         // Low half with visibility on, then upper half with it off.
         ea = 16'($urandom) & 16'h7FFF | {i[0], 15'h0};
         if (i == 1)
            bus(1'b1, 32'h8, 32'h0);
         req(psa_pkg::OP_DATA_READ, 1'b0, psa_pkg::IC_OTHER, 1'b0, 1'b0);
         `CHK("data_mem", 2'b10, {rsp.to_data_mem, rsp.remapped})
         `CHK("data_cost", 1, lat)
      end
      // Enable low holds the sequencer: a waiting request is neither taken nor answered.
      @(posedge i_clk);
      ce <= 1'b0;
      rq <= '{op: psa_pkg::OP_DATA_READ, effective_address: 16'h0123, byte_mode: 1'b0,
         wdata: 16'h0000, iclass: psa_pkg::IC_OTHER, in_loop: 1'b0, loop_edge: 1'b0};
      rq_v <= 1'b1;
      repeat (3)
      begin
         @(posedge i_clk);
         `CHK("ce_freeze", 2'b10, {rq_rdy, rsp_v})
      end
      rq_v <= 1'b0;
      ce <= 1'b1;
      // Implemented configuration area reads fine.
      ea = 16'($urandom);
      bus(1'b1, 32'h0, 32'hF8);
      req(psa_pkg::OP_TABLE_READ_HIGH, 1'b0, psa_pkg::IC_OTHER, 1'b0, 1'b0);
      w = pm.pm_word({8'hF8, ea});
      `CHK("cfg_read", {1'b0, 8'h00, w[23:16]}, {rsp.refused, rsp.rdata})
      // Outside the implemented area, and any write, is refused.
      bus(1'b1, 32'h0, 32'h80);
      req(psa_pkg::OP_TABLE_READ_LOW, 1'b0, psa_pkg::IC_OTHER, 1'b0, 1'b0);
      `CHK("cfg_hole", {1'b1, 16'h0000}, {rsp.refused, rsp.rdata})
      req(psa_pkg::OP_TABLE_WRITE_HIGH, 1'b0, psa_pkg::IC_OTHER, 1'b0, 1'b0);
      `CHK("cfg_write", 2'b10, {rsp.refused, seen})
      bus(1'b1, 32'hC, 32'hFFFFFFFF);
      bus(1'b0, 32'hC, 32'h0);
      `CHK("status", 22'h2, {rd[31:18], rd[15:8]})
      for (int i = 0; i < 2; i++)
      begin
         tp = 8'($urandom) & 8'h7F;
         ea = 16'($urandom) & 16'hFFFE;
         bus(1'b1, 32'h0, {24'h0, tp});
         // Low write in word mode, high write in byte mode on the lower byte.
         req(i ? psa_pkg::OP_TABLE_WRITE_HIGH : psa_pkg::OP_TABLE_WRITE_LOW, i[0],
            psa_pkg::IC_OTHER, 1'b0, 1'b0);
         `CHK("latch", {2'b01, tp, ea, i[0], ea ^ 16'h5A5A},
            {rsp.refused, seen, lts.addr, lts.high, lts.data})
         `CHK("latch_lanes", (i[0] ? 2'h1 : 2'h3), lts.lanes)
      end
      test_done();
   end
endmodule : psa_top_bench
`default_nettype wire
